// ===== pkg/nes_pkg.sv
// constants and types shared by both ends of the flash command link
// Summary of operation
// - dual erase: two setups, then confirm
// - dual erase result read by group status
// - even blocks group 0, odd group 1
// - host picks at most one block per group
// - either group order, no address relation
// - host ends with confirm or reset
// - five id bytes, fifth gives group count
// - third id byte: chips, cells, reserved
// - fourth id byte: page, block, width
// - status byte driven on each read strobe
// - status command accepted during reads
// - status layout: fails, zeros, ready, protect
// - fail bits valid only when ready
// - bit 0 gives current result
// - bit 1 gives previous result
// - bit 6 equals bit 5 without cache
// - each device reports its own status
// - reset aborts, discharges, then waits
// - reset may abort previous page too
// - erase starts on confirm write edge
// - while busy only status or reset; code also accepts group status
// - group status bit 0 ORs group fails
package nes_pkg;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_GRP_STATUS = 8'h71;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] ID_BYTE3 = 8'h90;
    localparam logic [7:0] ID_BYTE4 = 8'h15;
    localparam logic [7:0] ID_BYTE5 = 8'h76;
    localparam int ROW_BYTES = 3;
    localparam int ROW_W = 8 * ROW_BYTES;
    localparam int PAGE_W = 6;
    localparam int BLK_W = 11;
    localparam logic [2:0] ID_LAST = 3'h4;
    localparam logic [5:0] RST_BUSY_CYCLES = 6'h14;
    localparam logic [4:0] STROBE_CYCLES = 5'h0A;
    localparam logic [4:0] GUARD_CYCLES = 5'h10;
    // ce_n, cle, ale, we_n, read_strobe_n, wp_n, byte port
    localparam logic [13:0] PIN_SYNC_RST = 14'h2700;
    typedef enum logic [1:0] {NES_K_END, NES_K_CMD, NES_K_ADDR, NES_K_READ} nes_kind_t;
    typedef enum logic [2:0] {
        NES_OP_ERASE1, NES_OP_ERASE2, NES_OP_READ_ID, NES_OP_STATUS, NES_OP_GSTATUS, NES_OP_RESET
    } nes_op_t;
endpackage : nes_pkg

// ===== pkg/nes_link_if.sv
// pin level link between flash host and flash device
`timescale 1ns/1ps
`default_nettype none
interface nes_link_if;
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
    logic [7:0] host_dq;
    logic host_dq_oe;
    logic [7:0] dev_dq;
    logic dev_dq_oe;
    logic rb_drive;
    logic rb_drive_oe;
    wire [7:0] shared_byte_port;
    wire ready_busy_n;
    // bus keeper high when nobody drives; open drain busy line pulled up
    assign shared_byte_port = host_dq_oe ? host_dq : (dev_dq_oe ? dev_dq : 8'hFF);
    assign ready_busy_n = (rb_drive_oe && !rb_drive) ? 1'b0 : 1'b1;
    modport host (
        output ce_n, cle, ale, we_n, read_strobe_n, wp_n, host_dq, host_dq_oe,
        input shared_byte_port, ready_busy_n
    );
    modport dev (
        input ce_n, cle, ale, we_n, read_strobe_n, wp_n, shared_byte_port,
        output dev_dq, dev_dq_oe, rb_drive, rb_drive_oe
    );
endinterface : nes_link_if
`default_nettype wire

// ===== rtl/nes_device.sv
// flash device end: erase, id, status and reset command handling
`timescale 1ns/1ps
`default_nettype none
module nes_device #(
    parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h3C // arbitrary value
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // link pins
    nes_link_if.dev link,
    // memory array side
    output logic erase_start_out,
    output logic [1:0] erase_grp_out,
    output logic [nes_pkg::BLK_W-1:0] erase_blk0_out,
    output logic [nes_pkg::BLK_W-1:0] erase_blk1_out,
    output logic abort_out,
    input wire logic erase_done_in,
    input wire logic [1:0] erase_fail_in
);
    import nes_pkg::*;

    typedef enum logic [1:0] {NES_M_IDLE, NES_M_ID, NES_M_STAT, NES_M_GSTAT} nes_mode_t;

    logic [13:0] pin_s1_r;
    logic [13:0] pin_s2_r;
    logic we_prev_r;
    logic re_prev_r;
    logic ce_n_s, cle_s, ale_s, we_s, re_s, wp_n_s;
    logic [7:0] d_s;
    logic we_rise, re_fall, re_rise;
    nes_mode_t mode_r;
    logic in_erase_r;
    logic [1:0] addr_cnt_r;
    logic [ROW_W-1:0] row_r;
    logic [ROW_W-1:0] row_nxt;
    logic [BLK_W-1:0] blk_nxt;
    logic [1:0] grp_sel_r;
    logic erase_busy_r;
    logic [5:0] rst_cnt_r;
    logic busy;
    logic cur_fail_r;
    logic prev_fail_r;
    logic [1:0] gfail_r;
    logic [2:0] id_idx_r;
    logic [7:0] dq_out_r;
    logic dq_oe_r;
    logic rb_oe_r;
    logic [7:0] read_byte;

    function automatic logic busy_cmd_ok(input logic [7:0] c);
        return (c == CMD_STATUS) || (c == CMD_GRP_STATUS) || (c == CMD_RESET);
    endfunction : busy_cmd_ok

    function automatic logic [7:0] id_byte(input logic [2:0] i);
        unique case (i)
            3'h0: return MAKER_CODE;
            3'h1: return DEVICE_CODE;
            3'h2: return ID_BYTE3;
            3'h3: return ID_BYTE4;
            default: return ID_BYTE5;
        endcase
    endfunction : id_byte

    // two stage synchroniser on every pin
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            pin_s1_r <= PIN_SYNC_RST;
            pin_s2_r <= PIN_SYNC_RST;
            we_prev_r <= 1'b1;
            re_prev_r <= 1'b1;
        end else begin
            pin_s1_r <= {link.ce_n, link.cle, link.ale, link.we_n, link.read_strobe_n,
                         link.wp_n, link.shared_byte_port};
            pin_s2_r <= pin_s1_r;
            we_prev_r <= pin_s2_r[10];
            re_prev_r <= pin_s2_r[9];
        end
    end

    assign {ce_n_s, cle_s, ale_s, we_s, re_s, wp_n_s, d_s} = pin_s2_r;
    assign we_rise = !ce_n_s && we_s && !we_prev_r;
    assign re_fall = !ce_n_s && !re_s && re_prev_r;
    assign re_rise = !ce_n_s && re_s && !re_prev_r;
    assign busy = erase_busy_r || (rst_cnt_r != 6'h00);
    assign row_nxt = {d_s, row_r[ROW_W-1:8]};
    assign blk_nxt = row_nxt[PAGE_W +: BLK_W];

    // command and address sequencing
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            mode_r <= NES_M_IDLE;
            in_erase_r <= 1'b0;
            addr_cnt_r <= 2'h0;
            row_r <= '0;
            grp_sel_r <= 2'h0;
            erase_busy_r <= 1'b0;
            rst_cnt_r <= 6'h00;
            cur_fail_r <= 1'b0;
            prev_fail_r <= 1'b0;
            gfail_r <= 2'h0;
            erase_start_out <= 1'b0;
            erase_grp_out <= 2'h0;
            erase_blk0_out <= '0;
            erase_blk1_out <= '0;
            abort_out <= 1'b0;
        end else begin
            erase_start_out <= 1'b0;
            abort_out <= 1'b0;
            if (rst_cnt_r != 6'h00) begin
                rst_cnt_r <= rst_cnt_r - 6'h01;
            end
            if (erase_busy_r && erase_done_in) begin
                erase_busy_r <= 1'b0;
                gfail_r <= erase_fail_in & grp_sel_r;
                cur_fail_r <= |(erase_fail_in & grp_sel_r);
                grp_sel_r <= 2'h0;
            end
            // busy ignores all but status, group status and reset
            if (we_rise && cle_s && (!busy || busy_cmd_ok(d_s))) begin
                unique case (d_s)
                    CMD_ERASE_SETUP: begin
                        in_erase_r <= 1'b1;
                        addr_cnt_r <= 2'h0;
                        mode_r <= NES_M_IDLE;
                    end
                    CMD_ERASE_GO: begin
                        if (in_erase_r && (grp_sel_r != 2'h0)) begin
                            in_erase_r <= 1'b0;
                            prev_fail_r <= cur_fail_r;
                            mode_r <= NES_M_IDLE;
                            if (!wp_n_s) begin
                                cur_fail_r <= 1'b1;
                                gfail_r <= grp_sel_r;
                                grp_sel_r <= 2'h0;
                            end else begin
                                erase_busy_r <= 1'b1;
                                erase_start_out <= 1'b1;
                                erase_grp_out <= grp_sel_r;
                            end
                        end
                    end
                    CMD_READ_ID: begin
                        mode_r <= NES_M_ID;
                        in_erase_r <= 1'b0;
                    end
                    CMD_STATUS: mode_r <= NES_M_STAT;
                    CMD_GRP_STATUS: mode_r <= NES_M_GSTAT;
                    CMD_RESET: begin
                        mode_r <= NES_M_IDLE;
                        in_erase_r <= 1'b0;
                        grp_sel_r <= 2'h0;
                        rst_cnt_r <= RST_BUSY_CYCLES;
                        if (erase_busy_r) begin
                            erase_busy_r <= 1'b0;
                            abort_out <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end else if (we_rise && ale_s && in_erase_r && !busy) begin
                row_r <= row_nxt;
                if (addr_cnt_r == 2'(ROW_BYTES - 1)) begin
                    addr_cnt_r <= 2'h0;
                    // either order; later pick in same group replaces earlier
                    if (blk_nxt[0]) begin
                        erase_blk1_out <= blk_nxt;
                        grp_sel_r[1] <= 1'b1;
                    end else begin
                        erase_blk0_out <= blk_nxt;
                        grp_sel_r[0] <= 1'b1;
                    end
                end else begin
                    addr_cnt_r <= addr_cnt_r + 2'h1;
                end
            end
        end
    end

    // byte returned on a read strobe; no cached ops so both ready bits match
    always_comb begin
        unique case (mode_r)
            NES_M_ID: read_byte = id_byte(id_idx_r);
            NES_M_STAT: read_byte = {wp_n_s, !busy, !busy, 3'b000,
                                     prev_fail_r, cur_fail_r};
            NES_M_GSTAT: read_byte = {wp_n_s, !busy, !busy, 2'b00,
                                      gfail_r, |gfail_r};
            NES_M_IDLE: read_byte = 8'hFF;
        endcase
    end

    // byte port output driver
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            id_idx_r <= 3'h0;
            dq_out_r <= 8'h00;
            dq_oe_r <= 1'b0;
        end else begin
            if (we_rise && cle_s && (d_s == CMD_READ_ID)) begin
                id_idx_r <= 3'h0;
            end else if (re_rise && (mode_r == NES_M_ID) && (id_idx_r != ID_LAST)) begin
                id_idx_r <= id_idx_r + 3'h1;
            end
            if (re_fall) begin
                dq_out_r <= read_byte;
                dq_oe_r <= 1'b1;
            end else if (re_rise || ce_n_s) begin
                dq_oe_r <= 1'b0;
            end
        end
    end

    // open drain busy pull down
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            rb_oe_r <= 1'b0;
        end else begin
            rb_oe_r <= busy;
        end
    end

    assign link.dev_dq = dq_out_r;
    assign link.dev_dq_oe = dq_oe_r;
    assign link.rb_drive = 1'b0;
    assign link.rb_drive_oe = rb_oe_r;
endmodule : nes_device
`default_nettype wire

// ===== rtl/nes_host.sv
// flash host end: sequences command, address and read strobes
`timescale 1ns/1ps
`default_nettype none
module nes_host #(
    parameter logic [4:0] STROBE = nes_pkg::STROBE_CYCLES
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // link pins
    nes_link_if.host link,
    // user command port
    input wire logic cmd_valid_in,
    input wire nes_pkg::nes_op_t cmd_op_in,
    input wire logic [nes_pkg::BLK_W-1:0] blk_a_in,
    input wire logic [nes_pkg::BLK_W-1:0] blk_b_in,
    input wire logic wp_n_in,
    output logic cmd_ready_out,
    output logic done_out,
    output logic [39:0] rdata_out
);
    import nes_pkg::*;

    typedef enum logic [1:0] {NES_H_IDLE, NES_H_LOW, NES_H_HIGH, NES_H_WAIT} nes_hstate_t;

    nes_hstate_t ph_r;
    nes_op_t op_r;
    logic [BLK_W-1:0] blk_a_r;
    logic [BLK_W-1:0] blk_b_r;
    logic [3:0] idx_r;
    logic [4:0] tcnt_r;
    logic [8:0] in_s1_r;
    logic [8:0] in_s2_r;
    logic ce_n_r, cle_r, ale_r, we_n_r, re_n_r, wp_n_r, dq_oe_r;
    logic [7:0] dq_r;
    logic [9:0] cur;
    logic [9:0] nxt;

    // one link cycle of an operation: kind and byte
    function automatic logic [9:0] step_of(input nes_op_t op, input logic [3:0] i,
                                           input logic [BLK_W-1:0] a,
                                           input logic [BLK_W-1:0] b);
        logic [ROW_W-1:0] ra;
        logic [ROW_W-1:0] rb;
        nes_kind_t k;
        logic [7:0] v;
        ra = ROW_W'(a) << PAGE_W;
        rb = ROW_W'(b) << PAGE_W;
        k = NES_K_END;
        v = 8'h00;
        unique case (op)
            NES_OP_ERASE1, NES_OP_ERASE2: begin
                if (i == 4'h0 || (i == 4'h4 && op == NES_OP_ERASE2)) begin
                    k = NES_K_CMD;
                    v = CMD_ERASE_SETUP;
                end else if (i <= 4'h3) begin
                    k = NES_K_ADDR;
                    v = 8'(ra >> (8 * (int'(i) - 1)));
                end else if (i <= 4'h7 && op == NES_OP_ERASE2) begin
                    k = NES_K_ADDR;
                    v = 8'(rb >> (8 * (int'(i) - 5)));
                end else if ((i == 4'h4) || (i == 4'h8)) begin
                    k = NES_K_CMD;
                    v = CMD_ERASE_GO;
                end
            end
            NES_OP_READ_ID: begin
                k = (i == 4'h0) ? NES_K_CMD : (i == 4'h1) ? NES_K_ADDR :
                    (i <= 4'h6) ? NES_K_READ : NES_K_END;
                v = (i == 4'h0) ? CMD_READ_ID : 8'h00;
            end
            NES_OP_STATUS, NES_OP_GSTATUS: begin
                k = (i == 4'h0) ? NES_K_CMD : (i == 4'h1) ? NES_K_READ : NES_K_END;
                v = (op == NES_OP_STATUS) ? CMD_STATUS : CMD_GRP_STATUS;
            end
            NES_OP_RESET: begin
                k = (i == 4'h0) ? NES_K_CMD : NES_K_END;
                v = CMD_RESET;
            end
            default: ;
        endcase
        return {k, v};
    endfunction : step_of

    assign cur = step_of(op_r, idx_r, blk_a_r, blk_b_r);
    assign nxt = step_of(op_r, idx_r + 4'h1, blk_a_r, blk_b_r);

    // synchronise byte port and busy line
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            in_s1_r <= 9'h1FF;
            in_s2_r <= 9'h1FF;
        end else begin
            in_s1_r <= {link.ready_busy_n, link.shared_byte_port};
            in_s2_r <= in_s1_r;
        end
    end

    // operation sequencer
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ph_r <= NES_H_IDLE;
            op_r <= NES_OP_STATUS;
            blk_a_r <= '0;
            blk_b_r <= '0;
            idx_r <= 4'h0;
            tcnt_r <= 5'h00;
            ce_n_r <= 1'b1;
            cle_r <= 1'b0;
            ale_r <= 1'b0;
            we_n_r <= 1'b1;
            re_n_r <= 1'b1;
            dq_r <= 8'h00;
            dq_oe_r <= 1'b0;
            cmd_ready_out <= 1'b1;
            done_out <= 1'b0;
            rdata_out <= 40'h0;
        end else begin
            done_out <= 1'b0;
            unique case (ph_r)
                NES_H_IDLE: begin
                    if (cmd_valid_in) begin
                        op_r <= cmd_op_in;
                        blk_a_r <= blk_a_in;
                        blk_b_r <= blk_b_in;
                        idx_r <= 4'h0;
                        tcnt_r <= 5'h00;
                        ce_n_r <= 1'b0;
                        cmd_ready_out <= 1'b0;
                        rdata_out <= 40'h0;
                        ph_r <= NES_H_LOW;
                    end
                end
                NES_H_LOW: begin
                    if (tcnt_r == 5'h00) begin
                        cle_r <= (cur[9:8] == NES_K_CMD);
                        ale_r <= (cur[9:8] == NES_K_ADDR);
                        we_n_r <= (cur[9:8] == NES_K_READ);
                        re_n_r <= (cur[9:8] != NES_K_READ);
                        dq_r <= cur[7:0];
                        dq_oe_r <= (cur[9:8] != NES_K_READ);
                    end
                    if (tcnt_r == STROBE - 5'h01) begin
                        if (cur[9:8] == NES_K_READ) begin
                            rdata_out <= {rdata_out[31:0], in_s2_r[7:0]};
                        end
                        we_n_r <= 1'b1;
                        re_n_r <= 1'b1;
                        tcnt_r <= 5'h00;
                        ph_r <= NES_H_HIGH;
                    end else begin
                        tcnt_r <= tcnt_r + 5'h01;
                    end
                end
                NES_H_HIGH: begin
                    if (tcnt_r == STROBE - 5'h01) begin
                        cle_r <= 1'b0;
                        ale_r <= 1'b0;
                        dq_oe_r <= 1'b0;
                        idx_r <= idx_r + 4'h1;
                        tcnt_r <= 5'h00;
                        if (nxt[9:8] != NES_K_END) begin
                            ph_r <= NES_H_LOW;
                        end else if (op_r == NES_OP_ERASE1 || op_r == NES_OP_ERASE2 ||
                                     op_r == NES_OP_RESET) begin
                            ph_r <= NES_H_WAIT;
                        end else begin
                            ce_n_r <= 1'b1;
                            done_out <= 1'b1;
                            cmd_ready_out <= 1'b1;
                            ph_r <= NES_H_IDLE;
                        end
                    end else begin
                        tcnt_r <= tcnt_r + 5'h01;
                    end
                end
                NES_H_WAIT: begin
                    // guard lets busy reach us before ready is trusted
                    if (tcnt_r != GUARD_CYCLES) begin
                        tcnt_r <= tcnt_r + 5'h01;
                    end else if (in_s2_r[8]) begin
                        ce_n_r <= 1'b1;
                        done_out <= 1'b1;
                        cmd_ready_out <= 1'b1;
                        ph_r <= NES_H_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            wp_n_r <= 1'b1;
        end else begin
            wp_n_r <= wp_n_in;
        end
    end

    assign link.ce_n = ce_n_r;
    assign link.cle = cle_r;
    assign link.ale = ale_r;
    assign link.we_n = we_n_r;
    assign link.read_strobe_n = re_n_r;
    assign link.wp_n = wp_n_r;
    assign link.host_dq = dq_r;
    assign link.host_dq_oe = dq_oe_r;
endmodule : nes_host
`default_nettype wire

// ===== verif/nes_link_properties.sv
// concurrent checks on the flash link pins
`timescale 1ns/1ps
`default_nettype none
module nes_link_properties (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // link pins
    input wire logic ce_n,
    input wire logic cle,
    input wire logic we_n,
    input wire logic read_strobe_n,
    input wire logic wp_n,
    input wire logic dev_dq_oe,
    input wire logic [7:0] shared_byte_port,
    input wire logic ready_busy_n
);
    import nes_pkg::*;
    logic [7:0] last_cmd_r;
    logic [2:0] rd_idx_r;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // command byte latched at write strobe rise
    sequence cmd_seq(logic [7:0] code);
        $rose(we_n) && cle && !ce_n && shared_byte_port == code;
    endsequence
    // byte taken by the host at read strobe rise
    sequence rd_seq(logic [7:0] code);
        $rose(read_strobe_n) && !ce_n && dev_dq_oe && last_cmd_r == code;
    endsequence
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            last_cmd_r <= 8'h00;
            rd_idx_r <= 3'h0;
        end else if ($rose(we_n) && cle && !ce_n) begin
            last_cmd_r <= shared_byte_port;
            rd_idx_r <= 3'h0;
        end else if ($rose(read_strobe_n) && rd_idx_r != 3'h7) begin
            rd_idx_r <= rd_idx_r + 3'h1;
        end
    end
    reset_busy_a: assert property (cmd_seq(CMD_RESET) |-> ##[3:8] !ready_busy_n)
        else $error("no busy after reset command");
    erase_busy_a: assert property (
        cmd_seq(CMD_ERASE_GO) ##0 wp_n |-> ##[3:8] !ready_busy_n)
        else $error("no busy after erase confirm");
    busy_hold_a: assert property ($fell(ready_busy_n) |-> (!ready_busy_n) [*8])
        else $error("busy released too early");
    status_zero_a: assert property (
        rd_seq(CMD_STATUS) |-> shared_byte_port[4:2] == 3'b000)
        else $error("unused status bits not zero");
    protect_bit_a: assert property (rd_seq(CMD_STATUS) |-> shared_byte_port[7] == wp_n)
        else $error("protect bit wrong");
    ready_pair_a: assert property (
        rd_seq(CMD_STATUS) |-> shared_byte_port[5] == shared_byte_port[6])
        else $error("ready bits differ");
    group_or_a: assert property (
        rd_seq(CMD_GRP_STATUS) |-> shared_byte_port[0] == |shared_byte_port[2:1])
        else $error("group fail summary wrong");
    id_third_a: assert property (
        rd_seq(CMD_READ_ID) ##0 rd_idx_r == 3'h2 |-> shared_byte_port[7:4] == 4'h9)
        else $error("third id byte reserved field wrong");
    // group count sits on byte bits 3 and 2
    id_fifth_a: assert property (
        rd_seq(CMD_READ_ID) ##0 rd_idx_r >= 3'h4 |-> shared_byte_port[3:2] == 2'b01)
        else $error("fifth id byte group count wrong");
    idle_quiet_a: assert property (ce_n [*6] |-> !dev_dq_oe)
        else $error("device drives port while deselected");
endmodule : nes_link_properties
`default_nettype wire

// ===== verif/nes_erase_id_status_reset_test.sv
// self-checking bench for both ends of the flash command link
`timescale 1ns/1ps
`default_nettype none
module nes_erase_id_status_reset_test;
    import nes_pkg::*;
    localparam logic [7:0] MAKER = 8'h5B; // arbitrary value
    localparam logic [7:0] DEVID = 8'hC4; // arbitrary value
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cmd_valid = 1'b0;
    nes_op_t cmd_op = NES_OP_STATUS;
    logic [BLK_W-1:0] blk_a = '0;
    logic [BLK_W-1:0] blk_b = '0;
    logic wp_n = 1'b1;
    logic erase_done = 1'b0;
    logic [1:0] fail_next = 2'b00;
    logic cmd_ready, done, erase_start, abort;
    logic [1:0] grp, exp_sel, exp_g;
    logic [BLK_W-1:0] blk0, blk1, exp_b0, exp_b1;
    logic [39:0] rdata;
    logic exp_cur = 1'b0;
    logic exp_prev = 1'b0;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int wait_left = 0;
    always #2 core_clk_in = ~core_clk_in;
    nes_link_if nes_link_if_inst ();
    nes_device #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID)) nes_device_inst (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(nes_link_if_inst),
        .erase_start_out(erase_start), .erase_grp_out(grp), .erase_blk0_out(blk0),
        .erase_blk1_out(blk1), .abort_out(abort), .erase_done_in(erase_done),
        .erase_fail_in(fail_next));
    nes_host nes_host_inst (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(nes_link_if_inst),
        .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .blk_a_in(blk_a), .blk_b_in(blk_b),
        .wp_n_in(wp_n), .cmd_ready_out(cmd_ready), .done_out(done), .rdata_out(rdata));
    nes_link_properties nes_link_properties_inst (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_n(nes_link_if_inst.ce_n),
        .cle(nes_link_if_inst.cle), .we_n(nes_link_if_inst.we_n),
        .read_strobe_n(nes_link_if_inst.read_strobe_n), .wp_n(nes_link_if_inst.wp_n),
        .dev_dq_oe(nes_link_if_inst.dev_dq_oe),
        .shared_byte_port(nes_link_if_inst.shared_byte_port),
        .ready_busy_n(nes_link_if_inst.ready_busy_n));
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic run_op(input nes_op_t op, input logic [BLK_W-1:0] a, input logic [BLK_W-1:0] b);
        int n;
        cmd_op <= op;
        blk_a <= a;
        blk_b <= b;
        cmd_valid <= 1'b1;
        @(posedge core_clk_in);
        while (cmd_ready !== 1'b1) @(posedge core_clk_in);
        cmd_valid <= 1'b0;
        for (n = 0; n < 3000 && done !== 1'b1; n++) @(posedge core_clk_in);
        check("op done", 40'h1, {39'h0, done});
    endtask : run_op
    // erase then read both status bytes
    task automatic erase(input logic two, input logic [BLK_W-1:0] a, input logic [BLK_W-1:0] b);
        fail_next <= 2'($urandom_range(0, 3));
        exp_sel = two ? 2'b11 : 2'b01 << a[0];
        exp_b0 = a[0] ? b : a;
        exp_b1 = a[0] ? a : b;
        run_op(two ? NES_OP_ERASE2 : NES_OP_ERASE1, a, b);
        exp_prev = exp_cur;
        exp_g = wp_n ? fail_next & exp_sel : exp_sel;
        exp_cur = wp_n ? |exp_g : 1'b1;
        run_op(NES_OP_GSTATUS, '0, '0);
        check("group status", {wp_n, 4'hC, exp_g, |exp_g}, rdata);
        run_op(NES_OP_STATUS, '0, '0);
        check("status", {wp_n, 5'h18, exp_prev, exp_cur}, rdata);
    endtask : erase
    // array model: finishes erases after a random delay
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        erase_done <= 1'b0;
        // host only resets while ready, so no erase is ever cut short
        if (rst_n_in && abort !== 1'b0) check("abort", 40'h0, {39'h0, abort});
        if (erase_start === 1'b1) begin
            check("erase groups", exp_sel, grp);
            if (exp_sel[0]) check("even block", exp_b0, blk0);
            if (exp_sel[1]) check("odd block", exp_b1, blk1);
            wait_left <= 12 + $urandom_range(0, 30);
        end else if (wait_left == 1) begin
            erase_done <= 1'b1;
            wait_left <= 0;
        end else if (wait_left > 1) begin
            wait_left <= wait_left - 1;
        end
        if (cycles == 50000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        logic [BLK_W-1:0] a, b;
        void'($urandom(52719));
        repeat (8) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        @(posedge core_clk_in);
        run_op(NES_OP_READ_ID, '0, '0);
        check("id bytes", {MAKER, DEVID, 8'h90, 8'h15, 8'h76}, rdata);
        run_op(NES_OP_STATUS, '0, '0);
        check("idle status", 40'hE0, rdata);
        for (int i = 0; i < 8; i++) begin
            a = {10'($urandom_range(0, 1023)), 1'b0};
            b = {10'($urandom_range(0, 1023)), 1'b1};
            if (i == 0) a = 11'h000;
            if (i == 0) b = 11'h7FF;
            if (i[0]) erase(1'b1, b, a);
            else erase(i < 6, a, b);
        end
        run_op(NES_OP_RESET, '0, '0);
        run_op(NES_OP_RESET, '0, '0);
        run_op(NES_OP_STATUS, '0, '0);
        check("status after reset", {wp_n, 5'h18, exp_prev, exp_cur}, rdata);
        wp_n <= 1'b0;
        erase(1'b1, 11'h004, 11'h00B);
        wp_n <= 1'b1;
        run_op(NES_OP_READ_ID, '0, '0);
        check("id bytes again", {MAKER, DEVID, 8'h90, 8'h15, 8'h76}, rdata);
        give_verdict();
    end
endmodule : nes_erase_id_status_reset_test
`default_nettype wire
